/* File: rtl/ccdc_defines.svh */
`ifndef CCDC_DEFINES_SVH
`define CCDC_DEFINES_SVH

// Register offsets.
`define CCDC_OFS_PECL0_COUNTS 10'h190
`define CCDC_OFS_PECL0_CONTROL 10'h191
`define CCDC_OFS_PECL1_COUNTS 10'h193
`define CCDC_OFS_PECL1_CONTROL 10'h194
`define CCDC_OFS_PAIR3_FIRST_COUNTS 10'h199
`define CCDC_OFS_PAIR3_PHASE 10'h19A
`define CCDC_OFS_PAIR3_SECOND_COUNTS 10'h19B
`define CCDC_OFS_PAIR3_CONTROL 10'h19C
`define CCDC_OFS_PAIR4_FIRST_COUNTS 10'h19E
`define CCDC_OFS_PAIR4_PHASE 10'h19F
`define CCDC_OFS_PAIR4_SECOND_COUNTS 10'h1A0
`define CCDC_OFS_PAIR4_CONTROL 10'h1A1
`define CCDC_OFS_VCO_DIV_SELECT 10'h1E0
`define CCDC_OFS_CLK_IN_CONTROL 10'h1E1
`define CCDC_OFS_SYS_POWER_ALIGN 10'h230
`define CCDC_OFS_COMMIT_UPDATE 10'h232

// Field positions.
`define CCDC_CNT_LOW_HI 7
`define CCDC_CNT_LOW_LO 4
`define CCDC_CNT_HIGH_HI 3
`define CCDC_CNT_HIGH_LO 0
`define CCDC_PECL_BYPASS 7
`define CCDC_PECL_NOSYNC 6
`define CCDC_PECL_FORCE 5
`define CCDC_PECL_START 4
`define CCDC_PAIR_BYP_SECOND 5
`define CCDC_PAIR_BYP_FIRST 4
`define CCDC_PAIR_NOSYNC 3
`define CCDC_PAIR_FORCE 2
`define CCDC_PAIR_START_SECOND 1
`define CCDC_PAIR_START_FIRST 0
`define CCDC_CLK_PD_SECTION 4
`define CCDC_CLK_PD_IFACE 3
`define CCDC_CLK_PD_VCO_CLK 2
`define CCDC_CLK_SEL_VCO 1
`define CCDC_CLK_BYP_VCODIV 0
`define CCDC_SYS_PD_ALIGN 2
`define CCDC_SYS_PD_BUFFERS 1
`define CCDC_SYS_SOFT_ALIGN 0
`define CCDC_UPD_BIT 0

// Reset values.
`define CCDC_RST_COUNTS 8'h00
`define CCDC_RST_PECL0_CONTROL 8'h80
`define CCDC_RST_PECL1_CONTROL 8'h00
`define CCDC_RST_ZERO 8'h00
`define CCDC_RST_VCO_DIV_SELECT 8'h02

// Number of register slots.
`define CCDC_NREG 16

`endif

/* File: rtl/ccdc_pkg.sv */
package ccdc_pkg;
    // Register bus request.
    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ccdc_bus_req_t;

    // Per divider state.
    typedef enum logic [1:0] {
        CCDC_ST_RUN = 2'b00,
        CCDC_ST_HOLD = 2'b01,
        CCDC_ST_FORCE = 2'b10,
        CCDC_ST_BYPASS = 2'b11
    } ccdc_div_state_t;

    // Control levels for one divider stage.
    typedef struct packed {
        logic bypass;
        logic hold;
        logic force_level;
        logic start_level;
        logic [3:0] phase;
    } ccdc_stage_ctl_t;
endpackage : ccdc_pkg

/* File: rtl/ccdc_core.sv */
// Summary of operation
// - Each divider holds each output level for low count plus high count plus two cycles.
// - Duty cycle correction is always on; counts change only the ratio.
// - Peripheral bypass powers down a divider and passes input; divider 0 resets bypassed.
// - Sync-ignore bit set makes a channel disregard the chip-level alignment request.
// - Force-level bit drives output static high or low; needs sync-ignore too.
// - Start-level bit selects high or low starting level; low after reset.
// - Each divider has a four-bit phase offset, reset to zero.
// - Pair channels have two parallel dividers with separate bypass bits; output takes the second unless bypassed.
// - Pairs share one force bit and have separate start bits per stage.
// - Three-bit select sets the VCO divider ratio; some codes hold output static.
// - Clock input control bit 4 powers down the whole clock input section.
// - Bit 3 powers down the VCO interface; bit 2 powers down VCO and clock.
// - Bit 1 selects VCO source, bit 0 bypasses the VCO divider.
// - System bit 2 powers down the alignment circuitry.
// - System bit 1 powers down all output buffers.
// - Soft alignment bit mirrors the pin inverted; falling edge triggers alignment.
// - Writing update bit copies buffers to active registers on next edge, and clears on that same edge.
//
// Local design decision: the address-and-strobe port.
`include "ccdc_defines.svh"
module ccdc_core #(
    parameter int NREG = `CCDC_NREG
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register bus.
    input wire ccdc_pkg::ccdc_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    // Alignment pin, active low.
    input wire logic align_pin_n,
    // Divided channel outputs: PECL 0, PECL 1, pair 3, pair 4.
    output logic [3:0] chan_out,
    // Channel divider outputs held static.
    output logic [3:0] chan_static,
    // Alignment pulse towards the channels.
    output logic align_pulse,
    // Clock section power and source controls.
    output logic pd_clk_section,
    output logic pd_vco_iface,
    output logic pd_vco_clk,
    output logic sel_vco,
    output logic byp_vco_div,
    output logic vco_div_static,
    output logic [2:0] vco_div_code,
    // Output buffer power-down and alignment circuitry power-down.
    output logic pd_out_buffers,
    output logic pd_align
);
    import ccdc_pkg::*;

    // The slot decode serves exactly this many registers.
    if (NREG != `CCDC_NREG) begin : g_nreg_check
        $error("ccdc_core: register count fixed");
    end

    logic [7:0] buf_reg [NREG];
    logic [7:0] act_reg [NREG];
    logic update_reg;
    logic [4:0] slot_idx;
    logic [3:0] slot_next;
    logic slot_hit;
    logic align_req;
    logic align_req_reg;
    logic [7:0] cnt_reg [6];
    logic [5:0] out_reg;
    logic [5:0] run_ok;
    logic [5:0] div_hold;
    logic [5:0] div_force;
    logic [5:0] div_bypass;
    logic [5:0] div_start;
    logic [7:0] div_counts [6];

    // Address to slot index.
    function automatic logic [4:0] ccdc_slot(input logic [9:0] a);
        case (a)
            `CCDC_OFS_PECL0_COUNTS: ccdc_slot = 5'h00;
            `CCDC_OFS_PECL0_CONTROL: ccdc_slot = 5'h01;
            `CCDC_OFS_PECL1_COUNTS: ccdc_slot = 5'h02;
            `CCDC_OFS_PECL1_CONTROL: ccdc_slot = 5'h03;
            `CCDC_OFS_PAIR3_FIRST_COUNTS: ccdc_slot = 5'h04;
            `CCDC_OFS_PAIR3_PHASE: ccdc_slot = 5'h05;
            `CCDC_OFS_PAIR3_SECOND_COUNTS: ccdc_slot = 5'h06;
            `CCDC_OFS_PAIR3_CONTROL: ccdc_slot = 5'h07;
            `CCDC_OFS_PAIR4_FIRST_COUNTS: ccdc_slot = 5'h08;
            `CCDC_OFS_PAIR4_PHASE: ccdc_slot = 5'h09;
            `CCDC_OFS_PAIR4_SECOND_COUNTS: ccdc_slot = 5'h0A;
            `CCDC_OFS_PAIR4_CONTROL: ccdc_slot = 5'h0B;
            `CCDC_OFS_VCO_DIV_SELECT: ccdc_slot = 5'h0C;
            `CCDC_OFS_CLK_IN_CONTROL: ccdc_slot = 5'h0D;
            `CCDC_OFS_SYS_POWER_ALIGN: ccdc_slot = 5'h0E;
            `CCDC_OFS_COMMIT_UPDATE: ccdc_slot = 5'h0F;
            default: ccdc_slot = 5'h10;
        endcase
    endfunction : ccdc_slot

    // Reset value of each slot.
    function automatic logic [7:0] ccdc_rst(input int i);
        case (i)
            1: ccdc_rst = `CCDC_RST_PECL0_CONTROL;
            3: ccdc_rst = `CCDC_RST_PECL1_CONTROL;
            12: ccdc_rst = `CCDC_RST_VCO_DIV_SELECT;
            default: ccdc_rst = `CCDC_RST_ZERO;
        endcase
    endfunction : ccdc_rst

    // Ratio of a count byte: low plus high plus two.
    function automatic logic [5:0] ccdc_ratio(input logic [7:0] c);
        ccdc_ratio = 6'({2'b00, c[`CCDC_CNT_LOW_HI:`CCDC_CNT_LOW_LO]}) +
            6'({2'b00, c[`CCDC_CNT_HIGH_HI:`CCDC_CNT_HIGH_LO]}) + 6'h02;
    endfunction : ccdc_ratio

    // Address decode.
    always_comb begin
        slot_idx = ccdc_slot(bus_req.addr);
        slot_hit = ~slot_idx[4];
        slot_next = slot_idx[3:0];
    end

    // Buffered registers written by software.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NREG; i++) begin
                buf_reg[i] <= ccdc_rst(i);
            end
        end else if (bus_req.wr && slot_hit && slot_next != 4'hF) begin
            buf_reg[slot_next] <= bus_req.wdata;
        end
    end

    // Update bit sets on write and clears itself on the same edge that makes the copy.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            update_reg <= 1'b0;
        end else if (bus_req.wr && slot_hit && slot_next == 4'hF && bus_req.wdata[`CCDC_UPD_BIT]) begin
            update_reg <= 1'b1;
        end else begin
            update_reg <= 1'b0;
        end
    end

    // Active registers copy the buffers on the edge after the update request.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NREG; i++) begin
                act_reg[i] <= ccdc_rst(i);
            end
        end else if (update_reg) begin
            for (int i = 0; i < NREG - 1; i++) begin
                act_reg[i] <= buf_reg[i];
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads return zero.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rdata <= 8'h00;
        end else if (bus_req.rd && slot_hit) begin
            bus_rdata <= (slot_next == 4'hF) ? {7'h00, update_reg} : buf_reg[slot_next];
        end else begin
            bus_rdata <= 8'h00;
        end
    end

    // Chip-level alignment request from pin and soft bit.
    always_comb begin
        align_req = ~align_pin_n | act_reg[14][`CCDC_SYS_SOFT_ALIGN];
    end

    // Release of the request triggers one alignment pulse unless powered down.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            align_req_reg <= 1'b0;
            align_pulse <= 1'b0;
        end else begin
            align_req_reg <= align_req;
            align_pulse <= align_req_reg & ~align_req & ~act_reg[14][`CCDC_SYS_PD_ALIGN];
        end
    end

    // Per stage controls: 0,1 PECL; 2,3 pair 3 first/second; 4,5 pair 4.
    always_comb begin
        div_counts[0] = act_reg[0];
        div_counts[1] = act_reg[2];
        div_counts[2] = act_reg[4];
        div_counts[3] = act_reg[6];
        div_counts[4] = act_reg[8];
        div_counts[5] = act_reg[10];
        div_bypass[0] = act_reg[1][`CCDC_PECL_BYPASS];
        div_bypass[1] = act_reg[3][`CCDC_PECL_BYPASS];
        div_bypass[2] = act_reg[7][`CCDC_PAIR_BYP_FIRST];
        div_bypass[3] = act_reg[7][`CCDC_PAIR_BYP_SECOND];
        div_bypass[4] = act_reg[11][`CCDC_PAIR_BYP_FIRST];
        div_bypass[5] = act_reg[11][`CCDC_PAIR_BYP_SECOND];
        div_hold[0] = align_req & ~act_reg[1][`CCDC_PECL_NOSYNC];
        div_hold[1] = align_req & ~act_reg[3][`CCDC_PECL_NOSYNC];
        div_hold[2] = align_req & ~act_reg[7][`CCDC_PAIR_NOSYNC];
        div_hold[3] = div_hold[2];
        div_hold[4] = align_req & ~act_reg[11][`CCDC_PAIR_NOSYNC];
        div_hold[5] = div_hold[4];
        // Forcing is valid only together with sync-ignore.
        div_force[0] = act_reg[1][`CCDC_PECL_NOSYNC];
        div_force[1] = act_reg[3][`CCDC_PECL_NOSYNC];
        div_force[2] = act_reg[7][`CCDC_PAIR_NOSYNC];
        div_force[3] = div_force[2];
        div_force[4] = act_reg[11][`CCDC_PAIR_NOSYNC];
        div_force[5] = div_force[4];
        div_start[0] = act_reg[1][`CCDC_PECL_START];
        div_start[1] = act_reg[3][`CCDC_PECL_START];
        div_start[2] = act_reg[7][`CCDC_PAIR_START_FIRST];
        div_start[3] = act_reg[7][`CCDC_PAIR_START_SECOND];
        div_start[4] = act_reg[11][`CCDC_PAIR_START_FIRST];
        div_start[5] = act_reg[11][`CCDC_PAIR_START_SECOND];
        run_ok = ~div_hold & ~div_bypass & {6{~act_reg[13][`CCDC_CLK_PD_SECTION]}};
    end

    // Half-rate counters: a 50 percent output at the programmed ratio.
    // Each edge position uses the total ratio, so duty stays corrected.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 6; i++) begin
                cnt_reg[i] <= 8'h00;
            end
            out_reg <= 6'h00;
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (!run_ok[i]) begin
                    // Hold at phase offset and starting level while stopped.
                    cnt_reg[i] <= {4'h0, ccdc_stage_phase(i)};
                    out_reg[i] <= div_start[i];
                end else if (cnt_reg[i] + 8'h01 >= 8'({2'b00, ccdc_ratio(div_counts[i])})) begin
                    cnt_reg[i] <= 8'h00;
                    out_reg[i] <= ~out_reg[i];
                end else begin
                    cnt_reg[i] <= cnt_reg[i] + 8'h01;
                end
            end
        end
    end

    // Phase offset of a stage.
    function automatic logic [3:0] ccdc_stage_phase(input int i);
        case (i)
            0: ccdc_stage_phase = act_reg[1][3:0];
            1: ccdc_stage_phase = act_reg[3][3:0];
            2: ccdc_stage_phase = act_reg[5][3:0];
            3: ccdc_stage_phase = act_reg[5][7:4];
            4: ccdc_stage_phase = act_reg[9][3:0];
            default: ccdc_stage_phase = act_reg[9][7:4];
        endcase
    endfunction : ccdc_stage_phase

    // Channel outputs: bypass passes the reference, force holds a level.
    always_comb begin
        chan_out[0] = div_force[0] ? act_reg[1][`CCDC_PECL_FORCE] : (div_bypass[0] ? clk_sys : out_reg[0]);
        chan_out[1] = div_force[1] ? act_reg[3][`CCDC_PECL_FORCE] : (div_bypass[1] ? clk_sys : out_reg[1]);
        chan_out[2] = div_force[2] ? act_reg[7][`CCDC_PAIR_FORCE] :
            (div_bypass[3] ? (div_bypass[2] ? clk_sys : out_reg[2]) : out_reg[3]);
        chan_out[3] = div_force[4] ? act_reg[11][`CCDC_PAIR_FORCE] :
            (div_bypass[5] ? (div_bypass[4] ? clk_sys : out_reg[4]) : out_reg[5]);
        chan_static = {div_force[4] | div_hold[4], div_force[2] | div_hold[2], div_force[1] | div_hold[1],
            div_force[0] | div_hold[0]};
    end

    // Clock section and system power controls.
    always_comb begin
        pd_clk_section = act_reg[13][`CCDC_CLK_PD_SECTION];
        pd_vco_iface = act_reg[13][`CCDC_CLK_PD_IFACE];
        pd_vco_clk = act_reg[13][`CCDC_CLK_PD_VCO_CLK];
        sel_vco = act_reg[13][`CCDC_CLK_SEL_VCO];
        byp_vco_div = act_reg[13][`CCDC_CLK_BYP_VCODIV];
        vco_div_code = act_reg[12][2:0];
        vco_div_static = (act_reg[12][2:0] == 3'h6) || (act_reg[12][2:0] == 3'h7);
        pd_out_buffers = act_reg[14][`CCDC_SYS_PD_BUFFERS];
        pd_align = act_reg[14][`CCDC_SYS_PD_ALIGN];
    end

    // Assertions, all on the system clock and quiet during reset.
    default clocking ccdc_cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    a_update_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
        update_reg |=> !update_reg) else $error("update bit did not clear");
    a_update_copies: assert property (@(posedge clk_sys) disable iff (sys_rst)
        update_reg |=> act_reg[14] == $past(buf_reg[14])) else $error("active copy wrong");
    a_align_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
        align_pulse |-> $past(align_req, 2) && !$past(align_req)) else $error("bad alignment pulse");
    a_align_pd: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pd_align && $past(pd_align) |-> !align_pulse) else $error("pulse while powered down");
    a_hold_ignore: assert property (@(posedge clk_sys) disable iff (sys_rst)
        act_reg[1][`CCDC_PECL_NOSYNC] |-> !div_hold[0]) else $error("ignored request held");
    a_force_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
        div_force[0] |-> chan_out[0] == act_reg[1][`CCDC_PECL_FORCE]) else $error("force level");
    a_hold_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !run_ok[1] |=> out_reg[1] == $past(div_start[1])) else $error("start level");
    a_ratio_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
        run_ok[2] && $past(run_ok[2]) |-> cnt_reg[2] < 8'h22) else $error("counter overrun");
    a_static_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
        vco_div_static |-> vco_div_code[2:1] == 2'b11) else $error("static code");
    // A bypassed PECL divider shows the reference clock.
    a_pecl_bypass: assert property (div_bypass[0] && !div_force[0] |->
        chan_out[0] == clk_sys) else $error("pecl bypass path");

    // A pair with both stages bypassed shows the reference clock.
    a_pair_bypass: assert property (div_bypass[4] && div_bypass[5] && !div_force[4] |->
        chan_out[3] == clk_sys) else $error("pair bypass path");

    // A stopped stage reloads its phase offset.
    a_phase_load: assert property (!run_ok[2] |=>
        cnt_reg[2] == {4'h0, $past(act_reg[5][3:0])}) else $error("phase load");

    // A powered-down clock section stops every divider.
    a_section_pd: assert property (pd_clk_section |->
        run_ok == 6'h00) else $error("divider ran in power-down");

    // Pin or soft bit holds an obeying channel.
    a_align_or: assert property ((!align_pin_n || act_reg[14][`CCDC_SYS_SOFT_ALIGN]) &&
        !act_reg[1][`CCDC_PECL_NOSYNC] |-> div_hold[0]) else $error("request not held");

    // The soft bit alone holds an obeying channel static.
    a_soft_hold: assert property (act_reg[14][`CCDC_SYS_SOFT_ALIGN] && !act_reg[3][`CCDC_PECL_NOSYNC] |->
        chan_static[1]) else $error("soft hold missing");

    // A pair set to ignore alignment holds neither stage.
    a_pair_ignore: assert property (act_reg[7][`CCDC_PAIR_NOSYNC] |->
        !div_hold[2] && !div_hold[3]) else $error("pair ignore");

    // The second PECL channel also ignores the request when told to.
    a_pecl1_ignore: assert property (act_reg[3][`CCDC_PECL_NOSYNC] |->
        !div_hold[1]) else $error("pecl ignore");

    // A forced PECL channel shows its force level.
    a_pecl1_force: assert property (div_force[1] |->
        chan_out[1] == act_reg[3][`CCDC_PECL_FORCE]) else $error("pecl force level");

    // A forced pair shows its shared force level.
    a_pair_force: assert property (div_force[2] |->
        chan_out[2] == act_reg[7][`CCDC_PAIR_FORCE]) else $error("pair force level");

    // The other pair follows its own force level.
    a_pair4_force: assert property (div_force[4] |->
        chan_out[3] == act_reg[11][`CCDC_PAIR_FORCE]) else $error("pair force level");

    // A stopped second stage sits at its own start level.
    a_pair_start: assert property (!run_ok[3] |=>
        out_reg[3] == $past(div_start[3])) else $error("pair start level");

    // Active registers move only on an update.
    a_active_hold: assert property (!update_reg |=>
        act_reg[13] == $past(act_reg[13])) else $error("active changed");

    // A write of one to the update bit raises the flag.
    a_update_set: assert property (bus_req.wr && slot_hit && slot_next == 4'hF &&
        bus_req.wdata[`CCDC_UPD_BIT] |=> update_reg) else $error("update not set");

    // The alignment pulse lasts one cycle.
    a_pulse_single: assert property (align_pulse |=>
        !align_pulse) else $error("long alignment pulse");

    // A running output toggles only when its counter wraps.
    a_ratio_steady: assert property ($past(run_ok[1]) && cnt_reg[1] != 8'h00 |->
        $stable(out_reg[1])) else $error("early toggle");

    // Read data is zero unless a read was taken.
    a_rdata_idle: assert property (!$past(bus_req.rd) |->
        bus_rdata == 8'h00) else $error("stray read data");

    c_update: cover property (@(posedge clk_sys) update_reg);
    c_align: cover property (@(posedge clk_sys) align_pulse);
    c_toggle: cover property (@(posedge clk_sys) run_ok[1] && out_reg[1] != $past(out_reg[1]));
    c_force: cover property (div_force[1] && chan_out[1]);
    c_bypass: cover property (div_bypass[0] && !div_force[0]);
endmodule : ccdc_core

/* File: test/ccdc_core_bench.sv */
`include "ccdc_defines.svh"
module ccdc_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ccdc_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic align_pin_n = 1'b1;
    ccdc_bus_req_t bus_req = '0;
    logic [7:0] bus_rdata;
    logic [3:0] chan_out;
    logic [3:0] chan_static;
    logic align_pulse, pd_clk_section, pd_vco_iface, pd_vco_clk, sel_vco, byp_vco_div, vco_div_static;
    logic [2:0] vco_div_code;
    logic pd_out_buffers, pd_align;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [9:0] ofs [16] = '{10'h190, 10'h191, 10'h193, 10'h194, 10'h199, 10'h19A, 10'h19B, 10'h19C,
        10'h19E, 10'h19F, 10'h1A0, 10'h1A1, 10'h1E0, 10'h1E1, 10'h230, 10'h232};
    logic [7:0] rst_val [16] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};

    // The clock runs at 20 MHz.
    always #25 clk_sys = ~clk_sys;

    ccdc_core u_ccdc_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .align_pin_n(align_pin_n), .chan_out(chan_out), .chan_static(chan_static), .align_pulse(align_pulse),
        .pd_clk_section(pd_clk_section), .pd_vco_iface(pd_vco_iface), .pd_vco_clk(pd_vco_clk),
        .sel_vco(sel_vco), .byp_vco_div(byp_vco_div), .vco_div_static(vco_div_static),
        .vco_div_code(vco_div_code), .pd_out_buffers(pd_out_buffers), .pd_align(pd_align));

    task summarize();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    // Each bus task raises its strobe after an edge and drops it after the taking edge.
    task bus_wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask : bus_wr

    task bus_rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req <= '0;
        #1 d = bus_rdata;
    endtask : bus_rd

    // A commit moves buffered values into the active set; levels are looked at once it has landed.
    task commit();
        bus_wr(`CCDC_OFS_COMMIT_UPDATE, 8'h01);
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : commit

    function automatic logic [7:0] pd_bits();
        return {3'b000, pd_clk_section, pd_vco_iface, pd_vco_clk, sel_vco, byp_vco_div};
    endfunction : pd_bits

    task check_resets();
        logic [7:0] d;
        for (int i = 0; i < 16; i++) begin
            bus_rd(ofs[i], d);
            chk("reset value", rst_val[i], d);
        end
        chk("power levels", 8'h00, pd_bits() | {7'h00, pd_out_buffers});
        chk("align power", 8'h00, {7'h00, pd_align});
        chk("vco code", 8'h02, {5'h00, vco_div_code});
        chk("vco static", 8'h00, {7'h00, vco_div_static});
        @(posedge clk_sys);
        #5 chk("bypass high", 8'h01, {7'h00, chan_out[0]});
        @(negedge clk_sys);
        #5 chk("bypass low", 8'h00, {7'h00, chan_out[0]});
    endtask : check_resets

    // Measures the high and low widths of one channel in clock cycles.
    task measure(input int ch, output int hi, output int lo);
        logic p;
        hi = 0;
        lo = 0;
        p = 1'b1;
        for (int k = 0; k < 200 && !(p === 1'b0 && chan_out[ch] === 1'b1); k++) begin
            p = chan_out[ch];
            @(posedge clk_sys);
            #1;
        end
        while (chan_out[ch] === 1'b1 && hi < 100) begin
            hi++;
            @(posedge clk_sys);
            #1;
        end
        while (chan_out[ch] === 1'b0 && lo < 100) begin
            lo++;
            @(posedge clk_sys);
            #1;
        end
    endtask : measure

    task count_pulses(output int n);
        n = 0;
        repeat (10) begin
            @(posedge clk_sys);
            #1 n += int'(align_pulse === 1'b1);
        end
    endtask : count_pulses

    task pin_align(input logic [7:0] exp_static, input int exp_pulses);
        int n;
        @(posedge clk_sys);
        align_pin_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 chk("pin hold", exp_static, {7'h00, chan_static[1]});
        @(posedge clk_sys);
        align_pin_n <= 1'b1;
        count_pulses(n);
        chk("pin pulses", 8'(exp_pulses), 8'(n));
    endtask : pin_align

    // Main sequence: resets, register access, commit, dividers, forcing and alignment.
    initial begin
        logic [7:0] d, v;
        int m, n, hi, lo;
        void'($urandom(31));
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        check_resets();
        bus_wr(10'h192, 8'h5A);
        bus_rd(10'h192, d);
        chk("unmapped", 8'h00, d);
        bus_rd(10'h3FF, d);
        chk("unmapped top", 8'h00, d);
        for (int i = 0; i < 15; i++) begin
            v = 8'($urandom);
            bus_wr(ofs[i], v);
            bus_rd(ofs[i], d);
            chk("readback", v, d);
        end
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        check_resets();
        // Clock input control bits one at a time, buffered until the commit.
        for (int b = 0; b < 5; b++) begin
            v = 8'h01 << b;
            bus_wr(`CCDC_OFS_CLK_IN_CONTROL, v);
            #1 chk("buffered", 8'h00, pd_bits());
            commit();
            chk("clock input", v, pd_bits());
            bus_wr(`CCDC_OFS_CLK_IN_CONTROL, 8'h00);
            commit();
        end
        for (int c = 0; c < 8; c++) begin
            bus_wr(`CCDC_OFS_VCO_DIV_SELECT, 8'(c));
            commit();
            chk("vco code", 8'(c), {5'h00, vco_div_code});
            chk("vco static", 8'(c >= 6), {7'h00, vco_div_static});
        end
        bus_wr(`CCDC_OFS_SYS_POWER_ALIGN, 8'h02);
        commit();
        chk("buffer power", 8'h01, {7'h00, pd_out_buffers});
        // Forcing needs the sync-ignore bit beside it.
        for (int f = 0; f < 2; f++) begin
            bus_wr(`CCDC_OFS_PECL1_CONTROL, 8'h40 | 8'(f << 5));
            bus_wr(`CCDC_OFS_PAIR3_CONTROL, 8'h08 | 8'(f << 2));
            commit();
            repeat (6) begin
                @(posedge clk_sys);
                #1 chk("force pecl", 8'(f), {7'h00, chan_out[1]});
                chk("force pair", 8'(f), {7'h00, chan_out[2]});
                chk("force static", 8'h03, {6'h00, chan_static[2:1]});
            end
        end
        // Ratios with the extreme counts first, then random ones.
        for (int t = 0; t < 4; t++) begin
            m = (t == 0) ? 0 : (t == 1) ? 15 : int'($urandom % 16);
            n = (t == 0) ? 0 : (t == 1) ? 15 : int'($urandom % 16);
            bus_wr(`CCDC_OFS_PECL1_COUNTS, {4'(m), 4'(n)});
            bus_wr(`CCDC_OFS_PECL1_CONTROL, 8'h00);
            bus_wr(`CCDC_OFS_PAIR4_SECOND_COUNTS, {4'(n), 4'(m)});
            bus_wr(`CCDC_OFS_PAIR4_CONTROL, 8'h10);
            commit();
            measure(1, hi, lo);
            chk("pecl high", 8'(m + n + 2), 8'(hi));
            chk("pecl low", 8'(m + n + 2), 8'(lo));
            measure(3, hi, lo);
            chk("pair high", 8'(m + n + 2), 8'(hi));
            chk("pair low", 8'(m + n + 2), 8'(lo));
        end
        // Soft alignment holds the channel, and its release gives one pulse.
        bus_wr(`CCDC_OFS_SYS_POWER_ALIGN, 8'h01);
        commit();
        chk("soft hold", 8'h01, {7'h00, chan_static[1]});
        bus_wr(`CCDC_OFS_SYS_POWER_ALIGN, 8'h00);
        bus_wr(`CCDC_OFS_COMMIT_UPDATE, 8'h01);
        count_pulses(n);
        chk("soft pulses", 8'h01, 8'(n));
        chk("soft release", 8'h00, {7'h00, chan_static[1]});
        pin_align(8'h01, 1);
        bus_wr(`CCDC_OFS_PECL1_CONTROL, 8'h40);
        commit();
        // An ignoring channel sits at its forced level, so it reads static either way.
        pin_align(8'h01, 1);
        bus_wr(`CCDC_OFS_SYS_POWER_ALIGN, 8'h04);
        commit();
        chk("align power", 8'h01, {7'h00, pd_align});
        pin_align(8'h01, 0);
        summarize();
    end

    // Watchdog cuts a hang short well after the sequence should have ended.
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        summarize();
    end
endmodule : ccdc_core_bench
